// ### ccm_block_formatter_bench.sv
`timescale 1ns/10ps
// ==========
// formatter bench
module ccm_block_formatter_bench;
   logic clock, rst, frame_start, slow, pay_valid, pay_ready, auth_ready, auth_valid;
   logic ctr_ready, ctr_valid, ctr_for_tag, busy;
   logic [15:0] payload_length, encryption_offset, sent;
   logic [7:0] pay_data, res;
   logic [127:0] auth_block, ctr_block;
   logic [103:0] nonce;
   logic [79:0] hdr;
   logic [3:0] tag_octets;
   int n_errors = 0;
   int checks_done = 0;
   ccmbf_formatter dut_u (.clock(clock), .rst(rst), .frame_start(frame_start),
      .source_device_address(nonce[103:88]), .destination_device_address(nonce[87:72]),
      .temporal_key_id(nonce[71:48]), .secure_frame_number(nonce[47:0]), .frame_header(hdr),
      .encryption_offset(encryption_offset), .security_reserved(res), .payload_length(payload_length),
      .pay_valid(pay_valid), .pay_data(pay_data), .pay_ready(pay_ready), .auth_ready(auth_ready),
      .auth_valid(auth_valid), .auth_block(auth_block), .ctr_ready(ctr_ready), .ctr_valid(ctr_valid),
      .ctr_block(ctr_block), .ctr_for_tag(ctr_for_tag), .tag_octets(tag_octets), .busy(busy));
   ccmbf_far_model far_u (.clock(clock), .rst(rst), .frame_start(frame_start), .busy(busy), .slow(slow),
      .plen(payload_length), .pay_ready(pay_ready), .pay_valid(pay_valid), .pay_data(pay_data),
      .auth_ready(auth_ready), .ctr_ready(ctr_ready), .sent_reg(sent));
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   task close_out;
      $display("errors %0d checks %0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task chk(input logic [127:0] seen, input logic [127:0] exp);
      checks_done++;
      if (seen !== exp) begin
         $display("wrong value at %0t: %h expected %h", $time, seen, exp);
         n_errors++;
      end
   endtask
   function automatic logic [103:0] rev(input logic [103:0] x);
      for (int i = 0; i < 13; i++) rev[8*i+:8] = x[103-8*i-:8];
   endfunction
   // bounded wait for an auth (0) or counter (1) handshake, seen at the falling edge
   task automatic wait_hs(input logic c);
      int t;
      t = 0;
      @(negedge clock);
      while (!(c ? ctr_valid && ctr_ready : auth_valid && auth_ready) && t < 300) begin
         @(negedge clock);
         t++;
      end
      if (t >= 300) begin
         n_errors++;
         close_out;
      end
   endtask
   task automatic run_frame(input logic [15:0] p, input logic [15:0] ofs, input logic sl, input logic rf);
      int i, j, b, s, lim, np, n;
      logic [127:0] e;
      logic [103:0] nr;
      @(posedge clock);
      nonce <= nonce + 104'h1;
      payload_length <= p;
      encryption_offset <= ofs;
      slow <= sl;
      frame_start <= 1'b1;
      @(posedge clock);
      frame_start <= 1'b0;
      nr = rev(nonce);
      np = (ofs + 15) / 16;
      n = 2 + np + (p - ofs + 15) / 16;
      chk(128'(tag_octets), 128'h8);
      for (i = 0; i < n; i++) begin
         wait_hs(1'b0);
         b = i - 2;
         s = (b < np) ? b * 16 : ofs + (b - np) * 16;
         lim = (b < np) ? ofs : p;
         e = {8'h59, nr, p - ofs};
         if (i == 1) e = {ofs + 16'h000e, hdr, ofs, res, 8'h00};
         if (i > 1) for (j = 0; j < 16; j++) e[127-8*j-:8] = (s + j < lim) ? 8'(s + j + 1) : 8'h00;
         chk(auth_block, e);
         if (rf && i == 1) begin
            @(posedge clock);
            frame_start <= 1'b1;
            @(posedge clock);
            frame_start <= 1'b0;
         end
      end
      for (i = 0; i <= (p - ofs + 15) / 16; i++) begin
         wait_hs(1'b1);
         chk(ctr_block, {8'h01, nr, 16'(i)});
         chk(128'(ctr_for_tag), 128'(i == 0));
      end
      for (i = 0; busy !== 1'b0 && i < 300; i++) @(negedge clock);
      chk(128'(busy), 128'h0);
      chk(128'(sent), 128'(p));
   endtask
   task frame_split;
      run_frame(16'h0014, 16'h0005, 1'b0, 1'b0);
   endtask
   task frame_aligned_slow_refused;
      run_frame(16'h0020, 16'h0010, 1'b1, 1'b1);
   endtask
   task frame_empty;
      run_frame(16'h0000, 16'h0000, 1'b1, 1'b0);
   endtask
   task frame_no_offset;
      run_frame(16'h0025, 16'h0000, 1'b0, 1'b0);
   endtask
   task frame_long_plain_slow;
      run_frame(16'h0030, 16'h0014, 1'b1, 1'b0);
   endtask
   initial begin
      rst = 1'b1;
      frame_start = 1'b0;
      slow = 1'b0;
      payload_length = 16'h0;
      encryption_offset = 16'h0;
      nonce = 104'h1a2b3c4d5e6f708192a3b4c5d6;
      hdr = 80'h0102030405060708090a;
      res = 8'h5a;
      repeat (8) @(posedge clock);
      rst <= 1'b0;
      frame_split;
      frame_aligned_slow_refused;
      frame_empty;
      frame_no_offset;
      frame_long_plain_slow;
      close_out;
   end
endmodule

// ### ccmbf_defines.svh
`ifndef CCMBF_DEFINES_SVH
`define CCMBF_DEFINES_SVH
`define CCMBF_B0_FLAGS     8'h59
`define CCMBF_A_FLAGS      8'h01
`define CCMBF_BLOCK_OCTETS 5'h10
`define CCMBF_NONCE_OCTETS 4'hd
`define CCMBF_HDR_OCTETS   4'ha
`define CCMBF_TAG_OCTETS   4'h8
`define CCMBF_AAD_BASE     16'h000e
`define CCMBF_CTR_INIT     16'h0000
`endif

// ### ccmbf_far_model.sv
`timescale 1ns/10ps
// ==========
// frame logic and cipher side; octet k carries k+1
module ccmbf_far_model (
   input wire logic   clock,
   input wire logic   rst,
   input wire logic   frame_start,
   input wire logic   busy,
   input wire logic   slow,
   input wire logic [15:0] plen,
   input wire logic   pay_ready,
   output logic       pay_valid,
   output logic [7:0] pay_data,
   output logic       auth_ready,
   output logic       ctr_ready,
   output logic [15:0] sent_reg
);
   logic [1:0] pace_reg;
   always_ff @(posedge clock) begin
      if (rst || (frame_start && !busy)) sent_reg <= 16'h0;
      else if (pay_valid && pay_ready) sent_reg <= sent_reg + 16'h1;
   end
   always_ff @(posedge clock) pace_reg <= rst ? 2'h0 : pace_reg + 2'h1;
   assign pay_valid = sent_reg < plen;
   assign pay_data = pay_valid ? sent_reg[7:0] + 8'h1 : ~sent_reg[7:0];
   assign auth_ready = !slow || pace_reg == 2'h3;
   assign ctr_ready = !slow || pace_reg == 2'h1;
endmodule

// ### ccmbf_formatter.sv
`timescale 1ns/10ps
`include "ccmbf_defines.svh"
// Operation
// - B0: flags 0x59, nonce, encrypted length
// - encrypted length placed high octet first
// - nonce placed least significant octet first
// - B1: aad length, header, offset, reserved, zero
// - aad length placed high octet first
// - header and offset in transmission order
// - plain then encrypted payload, separate blocks
// - last block of portion zero filled
// - fill octets never go to medium
// - earliest octet leftmost in block
// - counter block: flags 0x01, nonce, counter
// - counter zero per frame, increments
// - counter high first, nonce low first
// - counter blocks make key stream
// - tag eight octets, length two octets
// - nonce: source, destination, key id, number
module ccmbf_formatter
   import ccmbf_pkg::*;
(
   input  wire logic         clock,
   input  wire logic         rst,
   input  wire logic         frame_start,
   input  wire logic [15:0]  source_device_address,
   input  wire logic [15:0]  destination_device_address,
   input  wire logic [23:0]  temporal_key_id,
   input  wire logic [47:0]  secure_frame_number,
   input  wire logic [79:0]  frame_header,
   input  wire logic [15:0]  encryption_offset,
   input  wire logic [7:0]   security_reserved,
   input  wire logic [15:0]  payload_length,
   input  wire logic         pay_valid,
   input  wire logic [7:0]   pay_data,
   output logic              pay_ready,
   input  wire logic         auth_ready,
   output logic              auth_valid,
   output ccmbf_block_t      auth_block,
   input  wire logic         ctr_ready,
   output logic              ctr_valid,
   output ccmbf_block_t      ctr_block,
   output logic              ctr_for_tag,
   output logic [3:0]        tag_octets,
   output logic              busy
);
   // =========================================================
   // frame context
   ccmbf_state_t state_reg;
   ccmbf_nonce_t nonce_reg;
   logic [79:0]  hdr_reg;
   logic [15:0]  ofs_reg;
   logic [7:0]   resv_reg;
   logic [15:0]  len_reg;
   logic [15:0]  left_reg;
   logic [15:0]  ctr_reg;
   logic [15:0]  ctr_last_reg;
   logic         in_enc_reg;
   logic         pend_reg;
   ccmbf_block_t pk_block;
   logic [4:0]   pk_count;
   logic         pk_clear;
   logic         take;
   logic         portion_end;

   // nonce octets reversed so least significant octet leads
   function automatic ccmbf_nonce_t reverse_octets(input ccmbf_nonce_t n);
      ccmbf_nonce_t r;
      r = '0;
      for (int i = 0; i < 13; i++) begin
         r[8*i +: 8] = n[8*(12-i) +: 8];
      end
      return r;
   endfunction

   always_ff @(posedge clock) begin
      if (rst) begin
         nonce_reg <= '0;
         hdr_reg   <= '0;
         ofs_reg   <= 16'h0000;
         resv_reg  <= 8'h00;
         len_reg   <= 16'h0000;
      end else if (frame_start && state_reg == CCMBF_IDLE) begin
         nonce_reg <= {source_device_address, destination_device_address,
                       temporal_key_id, secure_frame_number};
         hdr_reg   <= frame_header;
         ofs_reg   <= encryption_offset;
         resv_reg  <= security_reserved;
         len_reg   <= payload_length;
      end
   end

   // =========================================================
   // payload packing
   assign take = pay_valid && pay_ready;
   assign portion_end = (pk_count == `CCMBF_BLOCK_OCTETS) ||
                        (left_reg == 16'h0000) ||
                        (!in_enc_reg && left_reg == 16'(len_reg - ofs_reg));
   assign pk_clear = (state_reg != CCMBF_PLD) || (pend_reg && auth_ready);

   ccmbf_octet_packer u_packer (
      .clock       (clock),
      .rst         (rst),
      .clear       (pk_clear),
      .octet_valid (take),
      .octet_data  (pay_data),
      .block_reg   (pk_block),
      .count_reg   (pk_count)
   );

   always_ff @(posedge clock) begin
      if (rst) begin
         pay_ready <= 1'b0;
      end else begin
         pay_ready <= (state_reg == CCMBF_PLD) && !pend_reg && !portion_end && !take;
      end
   end

   always_ff @(posedge clock) begin
      if (rst || state_reg != CCMBF_PLD) begin
         left_reg   <= (state_reg == CCMBF_B1) ? len_reg : 16'h0000;
         in_enc_reg <= (state_reg == CCMBF_B1) && (ofs_reg == 16'h0000);
         pend_reg   <= 1'b0;
      end else begin
         if (take) begin
            left_reg <= left_reg - 16'h0001;
         end
         if (!pend_reg && !take && portion_end && pk_count != 5'h00) begin
            pend_reg <= 1'b1;
         end else if (pend_reg && auth_ready) begin
            pend_reg <= 1'b0;
            if (left_reg == 16'(len_reg - ofs_reg)) begin
               in_enc_reg <= 1'b1;
            end
         end
         if (!pend_reg && pk_count == 5'h00 && left_reg == 16'(len_reg - ofs_reg)) begin
            in_enc_reg <= 1'b1;
         end
      end
   end

   // =========================================================
   // sequencing
   always_ff @(posedge clock) begin
      if (rst) begin
         state_reg <= CCMBF_IDLE;
      end else begin
         unique case (state_reg)
            CCMBF_IDLE: if (frame_start) state_reg <= CCMBF_B0;
            CCMBF_B0:   if (auth_valid && auth_ready) state_reg <= CCMBF_B1;
            CCMBF_B1:   if (auth_valid && auth_ready) begin
               state_reg <= (len_reg == 16'h0000) ? CCMBF_CTR : CCMBF_PLD;
            end
            CCMBF_PLD:  if (left_reg == 16'h0000 && !pend_reg && pk_count == 5'h00) begin
               state_reg <= CCMBF_CTR;
            end
            CCMBF_CTR:  if (ctr_valid && ctr_ready && ctr_reg == ctr_last_reg) begin
               state_reg <= CCMBF_DONE;
            end
            CCMBF_DONE: state_reg <= CCMBF_IDLE;
         endcase
      end
   end

   // =========================================================
   // authentication block output
   always_ff @(posedge clock) begin
      if (rst) begin
         auth_valid <= 1'b0;
         auth_block <= '0;
      end else if (auth_valid && !auth_ready) begin
         auth_valid <= auth_valid;
      end else begin
         auth_valid <= 1'b0;
         if (state_reg == CCMBF_B0 && !auth_valid) begin
            auth_valid <= 1'b1;
            auth_block <= {`CCMBF_B0_FLAGS, reverse_octets(nonce_reg),
                           16'(len_reg - ofs_reg)};
         end else if (state_reg == CCMBF_B1 && !auth_valid) begin
            auth_valid <= 1'b1;
            auth_block <= {16'(`CCMBF_AAD_BASE + ofs_reg),
                           hdr_reg, ofs_reg, resv_reg, 8'h00};
         end else if (state_reg == CCMBF_PLD && !pend_reg && !take && portion_end
                      && pk_count != 5'h00) begin
            auth_valid <= 1'b1;
            auth_block <= pk_block;
         end
      end
   end

   // =========================================================
   // counter blocks
   always_ff @(posedge clock) begin
      if (rst || state_reg == CCMBF_IDLE) begin
         ctr_reg      <= `CCMBF_CTR_INIT;
         ctr_last_reg <= 16'h0000;
         ctr_valid    <= 1'b0;
         ctr_block    <= '0;
         ctr_for_tag  <= 1'b0;
      end else begin
         ctr_last_reg <= 16'((32'(len_reg - ofs_reg) + 32'd15) >> 4);
         if (state_reg == CCMBF_CTR && !ctr_valid) begin
            ctr_valid   <= 1'b1;
            ctr_block   <= {`CCMBF_A_FLAGS, reverse_octets(nonce_reg), ctr_reg};
            ctr_for_tag <= (ctr_reg == 16'h0000);
         end else if (ctr_valid && ctr_ready) begin
            ctr_valid <= 1'b0;
            ctr_reg   <= ctr_reg + 16'h0001;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         busy       <= 1'b0;
         tag_octets <= 4'h0;
      end else begin
         busy       <= (state_reg != CCMBF_IDLE);
         tag_octets <= `CCMBF_TAG_OCTETS;
      end
   end
endmodule

// ### ccmbf_formatter_chk.sv
`timescale 1ns/10ps
// ==========
// port checks
module ccmbf_formatter_chk
   import ccmbf_pkg::*;
(
   input wire logic          clock,
   input wire logic          rst,
   input wire logic          frame_start,
   input wire logic [15:0]   payload_length,
   input wire logic [15:0]   encryption_offset,
   input wire logic          busy,
   input wire logic          auth_valid,
   input wire logic          auth_ready,
   input wire ccmbf_block_t  auth_block,
   input wire logic          ctr_valid,
   input wire logic          ctr_ready,
   input wire ccmbf_block_t  ctr_block,
   input wire logic          ctr_for_tag,
   input wire logic [3:0]    tag_octets,
   input wire logic          pay_valid,
   input wire logic          pay_ready
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   logic [15:0] last_ctr_reg;
   always_ff @(posedge clock) begin
      if (rst) last_ctr_reg <= 16'h0;
      else if (ctr_valid && ctr_ready) last_ctr_reg <= ctr_block[15:0];
   end
   a_auth_hold: assert property (auth_valid && !auth_ready |=> auth_valid && $stable(auth_block))
      else $error("auth block dropped early");
   a_ctr_hold: assert property (ctr_valid && !ctr_ready |=> ctr_valid && $stable(ctr_block))
      else $error("counter block dropped early");
   a_b0_start: assert property (frame_start && !busy |-> ##2 auth_valid && auth_block[127:120] == 8'h59
      && auth_block[15:0] == payload_length - encryption_offset) else $error("first block wrong");
   a_ctr_flags: assert property (ctr_valid |-> ctr_block[127:120] == 8'h01)
      else $error("counter flags wrong");
   a_tag_zero: assert property (ctr_valid && ctr_for_tag |-> ctr_block[15:0] == 16'h0)
      else $error("tag counter not zero");
   a_ctr_step: assert property (ctr_valid && !ctr_for_tag |-> ctr_block[15:0] == last_ctr_reg + 16'h1)
      else $error("counter skipped");
   a_tag_len: assert property (!$past(rst) |-> tag_octets == 4'h8)
      else $error("tag length wrong");
   a_ctr_after: assert property (ctr_valid |-> busy && !auth_valid)
      else $error("counter block overlaps auth");
   a_pay_gap: assert property (pay_valid && pay_ready |=> !pay_ready)
      else $error("payload taken back to back");
   a_pay_quiet: assert property (pay_ready |-> busy && !auth_valid && !ctr_valid)
      else $error("payload taken while a block waits");
   cover property (auth_valid && auth_ready);
   cover property (ctr_for_tag && ctr_ready);
   cover property (frame_start && busy);
endmodule
bind ccmbf_formatter ccmbf_formatter_chk chk_u (.clock(clock), .rst(rst), .frame_start(frame_start),
   .payload_length(payload_length), .encryption_offset(encryption_offset), .busy(busy),
   .auth_valid(auth_valid), .auth_ready(auth_ready), .auth_block(auth_block), .ctr_valid(ctr_valid),
   .ctr_ready(ctr_ready), .ctr_block(ctr_block), .ctr_for_tag(ctr_for_tag), .tag_octets(tag_octets),
   .pay_valid(pay_valid), .pay_ready(pay_ready));

// ### ccmbf_octet_packer.sv
`timescale 1ns/10ps
`include "ccmbf_defines.svh"
// packs octets leftmost first into a 16-octet block, zero fills the rest
module ccmbf_octet_packer
   import ccmbf_pkg::*;
(
   input  wire logic         clock,
   input  wire logic         rst,
   input  wire logic         clear,
   input  wire logic         octet_valid,
   input  wire logic [7:0]   octet_data,
   output ccmbf_block_t      block_reg,
   output logic [4:0]        count_reg
);
   always_ff @(posedge clock) begin
      if (rst || clear) begin
         block_reg <= '0;
         count_reg <= 5'h00;
      end else if (octet_valid && count_reg < `CCMBF_BLOCK_OCTETS) begin
         block_reg[8'(8'd127 - {count_reg[3:0], 3'b000}) -: 8] <= octet_data;
         count_reg <= count_reg + 5'h01;
      end
   end
endmodule

// ### ccmbf_pkg.sv
package ccmbf_pkg;
   typedef logic [127:0] ccmbf_block_t;
   typedef logic [103:0] ccmbf_nonce_t;
   typedef enum logic [5:0] {
      CCMBF_IDLE = 6'h01,
      CCMBF_B0   = 6'h02,
      CCMBF_B1   = 6'h04,
      CCMBF_PLD  = 6'h08,
      CCMBF_CTR  = 6'h10,
      CCMBF_DONE = 6'h20
   } ccmbf_state_t;
endpackage
